// >>> verilog/psbw_ctrl.sv
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module psbw_ctrl #(
   parameter logic [15:0] INIT_CYC = psbw_pkg::INIT_CYC,
   parameter logic [15:0] DEV_ID = psbw_pkg::DEV_ID_DEF
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic mem_clk,
   input wire logic mem_sel_b,
   input wire logic mem_latch_b,
   input wire logic mem_cfg_en,
   input wire logic mem_we_b,
   input wire logic [5:0] mem_addr_hi,
   input wire logic [15:0] mem_adq_in,
   output logic wait_o,
   output logic wait_oe_b,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata
);
   ////////////////////////////////////////////////////////////////////////////////
   // pin sampling; the system clock must run several times the memory clock
   logic [psbw_pkg::PIN_W-1:0] pins_s;
   logic s_mclk, s_sel_b, s_latch_b, s_cfg, s_we_b;
   logic [5:0] s_ahi;
   logic [15:0] s_adq;
   logic mclk_d_r, mrise, start, cfg_start, arr_start;
   logic [15:0] opcode;

   psbw_sync #(.W(psbw_pkg::PIN_W)) u_sync (
      .clk(clk),
      .rst_b(rst_b),
      .d({mem_clk, mem_sel_b, mem_latch_b, mem_cfg_en, mem_we_b, mem_addr_hi, mem_adq_in}),
      .q(pins_s)
   );
   assign {s_mclk, s_sel_b, s_latch_b, s_cfg, s_we_b, s_ahi, s_adq} = pins_s;

   // edge detect on the synchronised copy only
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         mclk_d_r <= 1'b0;
      end else begin
         mclk_d_r <= s_mclk;
      end
   end
   assign mrise = s_mclk & ~mclk_d_r;
   // access starts at the first memory edge with latch low
   assign start = mrise & ~s_sel_b & ~s_latch_b;
   assign cfg_start = start & s_cfg;
   assign arr_start = start & ~s_cfg;
   assign opcode = s_adq;

   ////////////////////////////////////////////////////////////////////////////////
   // state machine
   psbw_pkg::psbw_state_t state_r;
   logic [15:0] bcr_r, rcr_r;
   logic [15:0] init_cnt_r, dpd_age_r, low_cnt_r, high_cnt_r;
   logic [3:0] lat_cnt_r;
   logic dpd_req_r, overrun_r, refr_ok, wait_act, lat_done;

   // latency runs out on the edge that takes the first data word
   assign lat_done = mrise & ~s_sel_b & (lat_cnt_r == 4'h1);

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_r <= psbw_pkg::PSBW_ST_INIT;
      end else begin
         unique case (state_r)
            psbw_pkg::PSBW_ST_INIT: begin
               // accesses before the delay ends are ignored
               if (init_cnt_r >= INIT_CYC) begin
                  state_r <= psbw_pkg::PSBW_ST_IDLE;
               end
            end
            psbw_pkg::PSBW_ST_IDLE: begin
               if (dpd_req_r && s_sel_b) begin
                  state_r <= psbw_pkg::PSBW_ST_DPD;
               end else if (arr_start) begin
                  state_r <= psbw_pkg::PSBW_ST_LAT;
               end
            end
            psbw_pkg::PSBW_ST_LAT: begin
               if (s_sel_b) begin
                  state_r <= psbw_pkg::PSBW_ST_IDLE;
               end else if (lat_done) begin
                  state_r <= psbw_pkg::PSBW_ST_XFER;
               end
            end
            psbw_pkg::PSBW_ST_XFER: begin
               // a new latch under the same select starts the read
               if (s_sel_b) begin
                  state_r <= psbw_pkg::PSBW_ST_IDLE;
               end else if (arr_start) begin
                  state_r <= psbw_pkg::PSBW_ST_LAT;
               end
            end
            psbw_pkg::PSBW_ST_DPD: begin
               if (dpd_age_r >= psbw_pkg::DPD_CYC && low_cnt_r >= psbw_pkg::DPD_CYC) begin
                  state_r <= psbw_pkg::PSBW_ST_INIT;
               end
            end
            default: begin
               state_r <= psbw_pkg::PSBW_ST_INIT;
            end
         endcase
      end
   end

   // latency counter, loaded at the latch edge
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         lat_cnt_r <= 4'h0;
      end else if (arr_start && (state_r == psbw_pkg::PSBW_ST_IDLE ||
                                 state_r == psbw_pkg::PSBW_ST_XFER)) begin
         lat_cnt_r <= psbw_pkg::psbw_lat_cycles(
            bcr_r[psbw_pkg::BCR_LC_MSB:psbw_pkg::BCR_LC_LSB]);
      end else if (state_r == psbw_pkg::PSBW_ST_LAT && mrise && lat_cnt_r != 4'h0) begin
         lat_cnt_r <= lat_cnt_r - 4'h1;
      end
   end

   // early mode lets go one memory cycle before the last latency edge
   assign wait_act = (state_r == psbw_pkg::PSBW_ST_LAT) &&
      !(bcr_r[psbw_pkg::BCR_WAIT_EARLY] && lat_cnt_r == 4'h1);

   // wait pin driven only while selected and initialised
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wait_o <= 1'b1;
         wait_oe_b <= 1'b1;
      end else begin
         wait_o <= bcr_r[psbw_pkg::BCR_WAIT_POL] ? wait_act : ~wait_act;
         wait_oe_b <= s_sel_b || state_r == psbw_pkg::PSBW_ST_INIT ||
                      state_r == psbw_pkg::PSBW_ST_DPD;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // configuration program: A18 high points at the read-only id
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         bcr_r <= psbw_pkg::BCR_RST;
         rcr_r <= psbw_pkg::RCR_RST;
      end else if (cfg_start && state_r == psbw_pkg::PSBW_ST_IDLE &&
                   !s_ahi[psbw_pkg::A18_IDX]) begin
         if (s_ahi[psbw_pkg::A19_IDX]) begin
            bcr_r <= opcode;
         end else begin
            rcr_r <= opcode;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // timers; a stopped memory clock just freezes latency counting
   assign refr_ok = (mrise & s_sel_b) | (high_cnt_r >= psbw_pkg::REFR_HIGH_CYC);

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         init_cnt_r <= 16'h0000;
         dpd_age_r <= 16'h0000;
      end else begin
         init_cnt_r <= (state_r == psbw_pkg::PSBW_ST_INIT && init_cnt_r < INIT_CYC) ?
                       init_cnt_r + 16'h0001 : (state_r == psbw_pkg::PSBW_ST_INIT ?
                       init_cnt_r : 16'h0000);
         if (state_r != psbw_pkg::PSBW_ST_DPD) begin
            dpd_age_r <= 16'h0000;
         end else if (dpd_age_r != 16'hFFFF) begin
            dpd_age_r <= dpd_age_r + 16'h0001;
         end
      end
   end

   // select high and low durations, both saturating
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         high_cnt_r <= 16'h0000;
         low_cnt_r <= 16'h0000;
      end else begin
         if (!s_sel_b) begin
            high_cnt_r <= 16'h0000;
         end else if (high_cnt_r != 16'hFFFF) begin
            high_cnt_r <= high_cnt_r + 16'h0001;
         end
         if (refr_ok) begin
            low_cnt_r <= 16'h0000;
         end else if (!s_sel_b && low_cnt_r != 16'hFFFF) begin
            low_cnt_r <= low_cnt_r + 16'h0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // register port; overrun sticky, a new overrun beats the clear
   logic overrun_set;
   assign overrun_set = low_cnt_r == psbw_pkg::SEL_LOW_MAX_CYC &&
                        state_r != psbw_pkg::PSBW_ST_DPD;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         overrun_r <= 1'b0;
      end else if (overrun_set) begin
         overrun_r <= 1'b1;
      end else if (reg_wr && reg_addr == psbw_pkg::REG_STATUS &&
                   reg_wdata[psbw_pkg::STAT_OVERRUN]) begin
         overrun_r <= 1'b0;
      end
   end

   // request drops once deep power-down is reached
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         dpd_req_r <= 1'b0;
      end else if (reg_wr && reg_addr == psbw_pkg::REG_CTRL) begin
         dpd_req_r <= reg_wdata[psbw_pkg::CTRL_DPD_REQ];
      end else if (state_r == psbw_pkg::PSBW_ST_DPD) begin
         dpd_req_r <= 1'b0;
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         reg_rdata <= 16'h0000;
      end else if (!reg_rd) begin
         reg_rdata <= 16'h0000;
      end else begin
         unique case (reg_addr)
            psbw_pkg::REG_STATUS: begin
               reg_rdata <= 16'h0000;
               reg_rdata[psbw_pkg::STAT_READY] <= state_r != psbw_pkg::PSBW_ST_INIT &&
                                                   state_r != psbw_pkg::PSBW_ST_DPD;
               reg_rdata[psbw_pkg::STAT_DPD] <= state_r == psbw_pkg::PSBW_ST_DPD;
               reg_rdata[psbw_pkg::STAT_OVERRUN] <= overrun_r;
               reg_rdata[psbw_pkg::STAT_BURST] <= state_r == psbw_pkg::PSBW_ST_LAT ||
                                                   state_r == psbw_pkg::PSBW_ST_XFER;
            end
            psbw_pkg::REG_BUS_CFG: begin
               reg_rdata <= bcr_r;
            end
            psbw_pkg::REG_REFR_CFG: begin
               reg_rdata <= rcr_r;
            end
            psbw_pkg::REG_DEV_ID: begin
               reg_rdata <= DEV_ID;
            end
            psbw_pkg::REG_CTRL: begin
               reg_rdata <= {15'h0000, dpd_req_r};
            end
            default: begin
               reg_rdata <= 16'h0000;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   AST_LAT_HELD: assert property (
      state_r == psbw_pkg::PSBW_ST_LAT && lat_cnt_r > 4'h1 |-> wait_act)
      else $error("wait dropped before latency ran out");
   AST_LAT_THREE: assert property (
      arr_start && state_r == psbw_pkg::PSBW_ST_IDLE &&
      bcr_r[psbw_pkg::BCR_LC_MSB:psbw_pkg::BCR_LC_LSB] == psbw_pkg::LC_3CYC
      |=> lat_cnt_r == 4'h3 && state_r == psbw_pkg::PSBW_ST_LAT)
      else $error("code 101 did not load three cycles");
   AST_WAIT_LOW: assert property (
      !bcr_r[psbw_pkg::BCR_WAIT_POL] && !bcr_r[psbw_pkg::BCR_WAIT_EARLY] &&
      state_r == psbw_pkg::PSBW_ST_LAT |=> !wait_o)
      else $error("wait not driven low during latency");
   AST_CFG_BCR: assert property (
      cfg_start && state_r == psbw_pkg::PSBW_ST_IDLE && s_ahi[psbw_pkg::A19_IDX] &&
      !s_ahi[psbw_pkg::A18_IDX] |=> bcr_r == $past(s_adq) && $stable(rcr_r))
      else $error("bus config not taken from address");
   AST_CFG_RCR: assert property (
      cfg_start && state_r == psbw_pkg::PSBW_ST_IDLE && !s_ahi[psbw_pkg::A19_IDX] &&
      !s_ahi[psbw_pkg::A18_IDX] |=> rcr_r == $past(s_adq) && $stable(bcr_r))
      else $error("refresh config not selected by A19 low");
   AST_CFG_ID: assert property (
      cfg_start && s_ahi[psbw_pkg::A18_IDX] |=> $stable(bcr_r) && $stable(rcr_r))
      else $error("id select changed a register");
   AST_NO_CFG: assert property (
      !(start && s_cfg) |=> $stable(bcr_r) && $stable(rcr_r))
      else $error("config changed without config enable");
   AST_RELEASE: assert property (
      state_r == psbw_pkg::PSBW_ST_LAT && lat_done |=> state_r == psbw_pkg::PSBW_ST_XFER)
      else $error("wait not released at first data");
   AST_REFRESH: assert property (
      s_sel_b [*3] |=> low_cnt_r == 16'h0000)
      else $error("select high did not count as refresh");
   AST_INIT_BLOCK: assert property (
      state_r == psbw_pkg::PSBW_ST_INIT |=> state_r != psbw_pkg::PSBW_ST_LAT)
      else $error("access taken during initialisation");
   AST_OVERRUN: assert property (
      overrun_set |=> overrun_r)
      else $error("select low overrun not flagged");

   COV_WRITE: cover property (state_r == psbw_pkg::PSBW_ST_LAT ##[1:40]
                              state_r == psbw_pkg::PSBW_ST_XFER);
   COV_WR_RD: cover property (state_r == psbw_pkg::PSBW_ST_XFER ##1
                              state_r == psbw_pkg::PSBW_ST_LAT);
   COV_CFG: cover property (cfg_start && state_r == psbw_pkg::PSBW_ST_IDLE);
   COV_DPD: cover property (state_r == psbw_pkg::PSBW_ST_DPD ##1
                            state_r == psbw_pkg::PSBW_ST_INIT);
endmodule // psbw_ctrl

// >>> verilog/psbw_pkg.sv
// What this block does
// - wait held latency code cycles; codes 0 and 5 give three
// - latency code 101 gives three cycles
// - bit10 clear: active low; bit8 clear: during
// - refresh seen: select high at edge, or >15ns
// - program changes only bus or refresh register
// - new value comes from address lines
// - address line 19 picks target register
// - config access only with config enable
// - fixed or variable type, same latency
// - lines 18,19: 00 refresh, 01 bus, 1x id
package psbw_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // timing, all derived from the 100 MHz system clock
   localparam int CLK_PERIOD_NS = 10;
   localparam int T_SEL_LOW_MAX_NS = 4000;
   localparam int T_REFR_HIGH_NS = 15;
   localparam int T_INIT_US = 150;
   localparam int T_DPD_US = 10;
   // longest time rounds down
   localparam logic [15:0] SEL_LOW_MAX_CYC = 16'(T_SEL_LOW_MAX_NS / CLK_PERIOD_NS);
   // least times: the refresh gap rounds up, init and power-down divide without rounding
   localparam logic [15:0] REFR_HIGH_CYC =
      16'((T_REFR_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [15:0] INIT_CYC = 16'((T_INIT_US * 1000) / CLK_PERIOD_NS);
   localparam logic [15:0] DPD_CYC = 16'((T_DPD_US * 1000) / CLK_PERIOD_NS);

   ////////////////////////////////////////////////////////////////////////////////
   // register port offsets
   localparam logic [3:0] REG_STATUS = 4'h0;
   localparam logic [3:0] REG_BUS_CFG = 4'h1;
   localparam logic [3:0] REG_REFR_CFG = 4'h2;
   localparam logic [3:0] REG_DEV_ID = 4'h3;
   localparam logic [3:0] REG_CTRL = 4'h4;

   // status and control bits
   localparam int STAT_READY = 0;
   localparam int STAT_DPD = 1;
   localparam int STAT_OVERRUN = 2;
   localparam int STAT_BURST = 3;
   localparam int CTRL_DPD_REQ = 0;

   // bus_config_reg fields and reset values
   localparam int BCR_LC_MSB = 13;
   localparam int BCR_LC_LSB = 11;
   localparam int BCR_WAIT_POL = 10;
   localparam int BCR_WAIT_EARLY = 8;
   localparam logic [2:0] LC_3CYC = 3'h5;
   localparam logic [3:0] LAT_3CYC = 4'h3;
   localparam logic [15:0] BCR_RST = 16'h2800;
   localparam logic [15:0] RCR_RST = 16'h0000;
   localparam logic [15:0] DEV_ID_DEF = 16'h0A5A; // arbitrary value

   // upper address pins hold A21..A16
   localparam int A19_IDX = 3;
   localparam int A18_IDX = 2;
   localparam int PIN_W = 27;

   typedef enum logic [4:0] {
      PSBW_ST_INIT = 5'h01,
      PSBW_ST_IDLE = 5'h02,
      PSBW_ST_LAT = 5'h04,
      PSBW_ST_XFER = 5'h08,
      PSBW_ST_DPD = 5'h10
   } psbw_state_t;

   // latency cycles for a code; zero falls back to three
   function automatic logic [3:0] psbw_lat_cycles(input logic [2:0] code);
      logic [3:0] n;
      n = {1'b0, code};
      if (code == LC_3CYC || code == 3'h0) begin
         n = LAT_3CYC;
      end
      return n;
   endfunction

endpackage

// >>> verilog/psbw_sync.sv
`timescale 1ns/10ps
// two-flop synchroniser for pins from the memory controller
module psbw_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   // first stage feeds the second only
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule // psbw_sync

// >>> test/psbw_host_model.sv
`timescale 1ns/10ps
// memory controller model: select, latch, config enable and a slow memory clock
module psbw_host_model (
   input wire logic clk,
   output logic mem_clk,
   output logic mem_sel_b,
   output logic mem_latch_b,
   output logic mem_cfg_en,
   output logic mem_we_b,
   output logic [5:0] mem_addr_hi,
   output logic [15:0] mem_adq_in
);
   // memory clock stands low outside frames
   initial begin
      mem_clk = 1'b0;
      mem_sel_b = 1'b1;
      mem_latch_b = 1'b1;
      mem_cfg_en = 1'b0;
      mem_we_b = 1'b1;
      mem_addr_hi = 6'h15;
      mem_adq_in = 16'h5A5A;
   end

   // each level four system cycles, as the pin synchroniser needs at least three
   task automatic mem_cycle();
      repeat (4) @(posedge clk);
      mem_clk <= 1'b1;
      repeat (4) @(posedge clk);
      mem_clk <= 1'b0;
      mem_adq_in <= ~mem_adq_in;
      mem_addr_hi <= ~mem_addr_hi;
   endtask

   // one access of n clocked words; keep leaves select low for a following read
   task automatic access(input logic cfg, input logic we_b, input logic [5:0] ahi,
                         input logic [15:0] adq, input int n, input logic keep);
      @(posedge clk);
      mem_sel_b <= 1'b0;
      mem_latch_b <= 1'b0;
      mem_cfg_en <= cfg;
      mem_we_b <= we_b;
      mem_addr_hi <= ahi;
      mem_adq_in <= adq;
      mem_cycle();
      mem_latch_b <= 1'b1;
      mem_cfg_en <= 1'b0;
      repeat (n) mem_cycle();
      // select low is kept well under the 400-cycle limit
      if (!keep) begin
         mem_sel_b <= 1'b1;
         repeat (4) @(posedge clk);
      end
   endtask

   // select low with the clock stopped, then a refresh gap
   task automatic hold(input int n);
      @(posedge clk);
      mem_sel_b <= 1'b0;
      repeat (n) @(posedge clk);
      mem_sel_b <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
endmodule // psbw_host_model

// >>> test/psram_burst_write_cfg_program_tb_top.sv
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module psram_burst_write_cfg_program_tb_top;
   localparam logic [15:0] DEV_ID = 16'h1234; // arbitrary value
   logic clk;
   logic rst_b;
   logic mem_clk;
   logic mem_sel_b;
   logic mem_latch_b;
   logic mem_cfg_en;
   logic mem_we_b;
   logic [5:0] mem_addr_hi;
   logic [15:0] mem_adq_in;
   logic wait_o;
   logic wait_oe_b;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [15:0] reg_rdata;
   logic [15:0] exp_q[$];
   logic [15:0] mask_q[$];
   int lat_q[$];
   int err_count = 0;
   int n_compared = 0;
   int cycles = 0;
   int edge_cnt = 0;
   logic [15:0] lfsr = 16'hCC90;
   logic pol = 1'b0;
   logic mon_on = 1'b0;
   logic rd_d = 1'b0;
   logic act_d = 1'b0;
   logic mem_clk_d = 1'b0;

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   psbw_ctrl #(.INIT_CYC(16'h0014), .DEV_ID(DEV_ID)) i_dut (
      .clk(clk), .rst_b(rst_b), .mem_clk(mem_clk), .mem_sel_b(mem_sel_b),
      .mem_latch_b(mem_latch_b), .mem_cfg_en(mem_cfg_en), .mem_we_b(mem_we_b),
      .mem_addr_hi(mem_addr_hi), .mem_adq_in(mem_adq_in), .wait_o(wait_o),
      .wait_oe_b(wait_oe_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   psbw_host_model i_host (
      .clk(clk), .mem_clk(mem_clk), .mem_sel_b(mem_sel_b), .mem_latch_b(mem_latch_b),
      .mem_cfg_en(mem_cfg_en), .mem_we_b(mem_we_b), .mem_addr_hi(mem_addr_hi),
      .mem_adq_in(mem_adq_in));

   ////////////////////////////////////////
   function automatic logic [15:0] lfsr_next(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction

   task automatic end_of_test();
      if (err_count == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // read data is noted now and compared by the watcher a cycle later
   task automatic reg_check(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
      exp_q.push_back(e & m);
      mask_q.push_back(m);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask

   task automatic cfg_prog(input logic [5:0] ahi, input logic [15:0] op);
      i_host.access(1'b1, 1'b0, ahi, op, 2, 1'b0);
   endtask

   // array access; lat is the number of memory edges wait must cover
   task automatic burst(input logic we_b, input logic keep, input int lat);
      lat_q.push_back(lat);
      mon_on = 1'b1;
      lfsr = lfsr_next(lfsr);
      i_host.access(1'b0, we_b, lfsr[5:0], lfsr, 10, keep);
      mon_on = keep;
   endtask

   ////////////////////////////////////////
   // register read watcher
   always @(posedge clk) begin : watch_regs
      logic [15:0] m;
      logic [15:0] e;
      rd_d <= reg_rd;
      if (rd_d === 1'b1) begin
         m = mask_q.pop_front();
         e = exp_q.pop_front();
         `CHK(reg_rdata & m, e)
      end
   end

   // counts memory edges seen while wait is at its active level
   always @(posedge clk) begin : watch_wait
      logic act;
      act = mon_on && (wait_oe_b === 1'b0) && (wait_o === pol);
      mem_clk_d <= mem_clk;
      if (act && !act_d) edge_cnt = 0;
      if (act && mem_clk && !mem_clk_d) edge_cnt++;
      if (!act && act_d) begin
         `CHK(edge_cnt, lat_q.pop_front())
      end
      act_d <= act;
   end

   // hang guard, well above the expected few thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         end_of_test();
      end
   end

   ////////////////////////////////////////
   initial begin : main
      int lat;
      logic early;
      logic [2:0] code;
      logic [15:0] op;
      rst_b = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      repeat (40) @(posedge clk);
      reg_check(psbw_pkg::REG_STATUS, 16'h0001, 16'h0001);
      reg_check(psbw_pkg::REG_BUS_CFG, psbw_pkg::BCR_RST, 16'hFFFF);
      reg_check(psbw_pkg::REG_REFR_CFG, psbw_pkg::RCR_RST, 16'hFFFF);
      reg_check(psbw_pkg::REG_DEV_ID, DEV_ID, 16'hFFFF);
      reg_check(4'hF, 16'h0000, 16'hFFFF);
      reg_write(psbw_pkg::REG_BUS_CFG, lfsr);
      reg_check(psbw_pkg::REG_BUS_CFG, psbw_pkg::BCR_RST, 16'hFFFF);
      // default three-cycle latency, then write followed by read on one select
      burst(1'b0, 1'b0, 3);
      burst(1'b0, 1'b1, 3);
      burst(1'b1, 1'b0, 3);
      // every latency code, random type, polarity and early release
      for (int c = 0; c < 8; c++) begin
         lfsr = lfsr_next(lfsr);
         code = 3'(c);
         lat = (code == 3'h0 || code == 3'h5) ? 3 : c;
         early = (lat > 2) & lfsr[0];
         op = {1'b0, lfsr[1], code, lfsr[2], 1'b0, early, 8'h00};
         cfg_prog(6'h08, op);
         reg_check(psbw_pkg::REG_BUS_CFG, op, 16'hFFFF);
         pol = op[10];
         burst(lfsr[3], 1'b0, lat - int'(early));
      end
      reg_check(psbw_pkg::REG_BUS_CFG, op, 16'hFFFF);
      lfsr = lfsr_next(lfsr);
      cfg_prog(6'h00, lfsr);
      reg_check(psbw_pkg::REG_REFR_CFG, lfsr, 16'hFFFF);
      cfg_prog(6'h04, ~lfsr);
      cfg_prog(6'h0C, ~lfsr);
      reg_check(psbw_pkg::REG_REFR_CFG, lfsr, 16'hFFFF);
      reg_check(psbw_pkg::REG_BUS_CFG, op, 16'hFFFF);
      reg_check(psbw_pkg::REG_DEV_ID, DEV_ID, 16'hFFFF);
      // refresh gaps keep the select-low timer short; a long hold overruns
      i_host.hold(300);
      i_host.hold(300);
      reg_check(psbw_pkg::REG_STATUS, 16'h0000, 16'h0004);
      i_host.hold(450);
      reg_check(psbw_pkg::REG_STATUS, 16'h0004, 16'h0004);
      reg_write(psbw_pkg::REG_STATUS, 16'h0004);
      reg_check(psbw_pkg::REG_STATUS, 16'h0000, 16'h0004);
      // deep power-down entry, minimum stay, exit by select low, re-initialise
      reg_write(psbw_pkg::REG_CTRL, 16'h0001);
      repeat (4) @(posedge clk);
      reg_check(psbw_pkg::REG_STATUS, 16'h0002, 16'h0002);
      repeat (1010) @(posedge clk);
      i_host.hold(1010);
      repeat (40) @(posedge clk);
      reg_check(psbw_pkg::REG_STATUS, 16'h0001, 16'h0003);
      repeat (4) @(posedge clk);
      `CHK(lat_q.size(), 0)
      end_of_test();
   end
endmodule // psram_burst_write_cfg_program_tb_top
